// ---- core/ahs_axis.sv ----
// Axis homing sequencer, profile generator and smoothing filter with AHB-Lite registers
//
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ahs_defs.svh"

//
// Overview of operation
// - Edge find: slew until home edge, stop
// - Homing starts by accelerating to slew speed
// - Home state 1 reverse, 0 forward
// - Polarity setting maps switch level to state
// - Stage one decelerates on home change
// - Edge find picks direction like stage one
// - Stage two: homing speed, opposite, until toggle
// - Opposite stage three stops; same continues smoothly
// - Stage three forward to index, return
// - Index position becomes zero count
// - Servo factor 0..1, 1 means unfiltered
// - Servo factor filters profile moves on non-step axes only
// - Step factor 0.25..64, 0.25 unfiltered
// - Step factor only on step axes
module ahs_axis
   import ahs_pkg::*;
#(
   parameter int VW = 32
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic tick,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic home_pin,
   input wire logic index_pin,
   input wire logic enc_pulse_pin,
   input wire logic enc_dir_pin,
   output logic [VW-1:0] motor_vel,
   output logic motor_dir,
   output logic motion_complete
);

   function automatic logic [3:0] ahs_log2(input logic [8:0] q);
      ahs_log2 = 4'h0;
      for (int i = 1; i < 9; i++) begin
         if (q[i]) begin
            ahs_log2 = 4'(i);
         end
      end
   endfunction : ahs_log2

   // Pin synchronisers
   ahs_pins_s pin_raw;
   ahs_pins_s s1_r, s2_r, s3_r, filt_r, filt_nxt, filt_d_r;
   assign pin_raw = '{home: home_pin, index: index_pin, enc_pulse: enc_pulse_pin, enc_dir: enc_dir_pin};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_filt
         assign filt_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : filt_r[gi];
      end
   endgenerate

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         filt_r <= '0;
         filt_d_r <= '0;
      end else if (ce) begin
         s1_r <= pin_raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
         filt_r <= filt_nxt;
         filt_d_r <= filt_r;
      end
   end

   // Register bank state
   ahs_cfg_s cfg_r, cfg_nxt;
   logic [VW-1:0] slew_r, slew_nxt, hvel_r, hvel_nxt, acc_r, acc_nxt, dec_r, dec_nxt;
   logic [8:0] servo_r, servo_nxt, step_r, step_nxt;
   logic mode_home_r, mode_home_nxt, mode_set_r, mode_set_nxt;
   logic wr_pend_r, wr_pend_nxt;
   logic [7:0] wr_addr_r, wr_addr_nxt;
   logic [31:0] hrdata_r, hrdata_nxt;
   logic acc_take, wr_now;

   // Motion state
   ahs_state_e state_r, state_nxt;
   logic signed [VW-1:0] pos_r, pos_nxt, v_r, v_nxt, vf_r, vf_nxt, tgt_r, tgt_nxt;
   logic rev1_r, rev1_nxt, href_r, href_nxt, done_r, done_nxt, idx_r, idx_nxt, edge_mode_r, edge_mode_nxt;
   logic home_state, stopped, start_cmd, abort_cmd, kill;
   logic cmd_wr, mode_set_eff, mode_home_eff;

   assign home_state = filt_r.home ^ cfg_r.pol_pos;
   assign stopped = (v_r == '0) && (vf_r == '0);
   assign acc_take = ce && hsel && htrans[1] && hready;
   assign wr_now = ce && wr_pend_r;
   assign start_cmd = wr_now && (wr_addr_r == `AHS_OFF_CMD) && hwdata[`AHS_CMD_BEGIN];
   assign abort_cmd = wr_now && (wr_addr_r == `AHS_OFF_CMD) && hwdata[`AHS_CMD_ABORT];
   // Mode bits in the same write as begin take effect at once
   assign cmd_wr = wr_now && (wr_addr_r == `AHS_OFF_CMD);
   assign mode_set_eff = mode_set_r || (cmd_wr && (hwdata[`AHS_CMD_EDGE] || hwdata[`AHS_CMD_HOME]));
   assign mode_home_eff = (cmd_wr && hwdata[`AHS_CMD_HOME]) ? 1'b1 :
      ((cmd_wr && hwdata[`AHS_CMD_EDGE]) ? 1'b0 : mode_home_r);

   assign hreadyout = ce;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   // Bus slave and configuration registers
   always_comb begin
      cfg_nxt = cfg_r;
      slew_nxt = slew_r;
      hvel_nxt = hvel_r;
      acc_nxt = acc_r;
      dec_nxt = dec_r;
      servo_nxt = servo_r;
      step_nxt = step_r;
      mode_home_nxt = mode_home_r;
      mode_set_nxt = mode_set_r;
      wr_pend_nxt = wr_pend_r;
      wr_addr_nxt = wr_addr_r;
      hrdata_nxt = hrdata_r;
      if (wr_now) begin
         case (wr_addr_r)
            `AHS_OFF_CMD: begin
               if (hwdata[`AHS_CMD_EDGE]) begin
                  mode_home_nxt = 1'b0;
                  mode_set_nxt = 1'b1;
               end
               if (hwdata[`AHS_CMD_HOME]) begin
                  mode_home_nxt = 1'b1;
                  mode_set_nxt = 1'b1;
               end
            end
            `AHS_OFF_CFG: begin
               cfg_nxt.pol_pos = hwdata[`AHS_CFG_POL];
               cfg_nxt.step_axis = hwdata[`AHS_CFG_STEP];
            end
            `AHS_OFF_SLEW: slew_nxt = hwdata[VW-1:0];
            `AHS_OFF_HVEL: hvel_nxt = hwdata[VW-1:0];
            `AHS_OFF_ACC: acc_nxt = hwdata[VW-1:0];
            `AHS_OFF_DEC: dec_nxt = hwdata[VW-1:0];
            `AHS_OFF_SERVO: begin
               servo_nxt = (hwdata[31:0] > 32'(`AHS_SERVO_ONE)) ? `AHS_SERVO_ONE : hwdata[8:0];
            end
            `AHS_OFF_STEP: begin
               if (hwdata[31:0] > 32'(`AHS_STEP_MAX)) begin
                  step_nxt = `AHS_STEP_MAX;
               end else if (hwdata[8:0] < `AHS_STEP_MIN) begin
                  step_nxt = `AHS_STEP_MIN;
               end else begin
                  step_nxt = hwdata[8:0];
               end
            end
            default: begin
            end
         endcase
      end
      if (start_cmd && state_r == AHS_IDLE) begin
         mode_set_nxt = 1'b0;
      end
      if (ce) begin
         wr_pend_nxt = acc_take && hwrite && (hsize == `AHS_HSIZE_WORD);
      end
      if (acc_take) begin
         wr_addr_nxt = haddr[7:0];
         hrdata_nxt = 32'h0000_0000;
         if (!hwrite) begin
            case (haddr[7:0])
               `AHS_OFF_CFG: hrdata_nxt = {30'h0, cfg_r.step_axis, cfg_r.pol_pos};
               `AHS_OFF_SLEW: hrdata_nxt = 32'(slew_r);
               `AHS_OFF_HVEL: hrdata_nxt = 32'(hvel_r);
               `AHS_OFF_ACC: hrdata_nxt = 32'(acc_r);
               `AHS_OFF_DEC: hrdata_nxt = 32'(dec_r);
               `AHS_OFF_SERVO: hrdata_nxt = {23'h0, servo_r};
               `AHS_OFF_STEP: hrdata_nxt = {23'h0, step_r};
               `AHS_OFF_STATUS: begin
                  hrdata_nxt = {25'h0, state_r, idx_r, (state_r != AHS_IDLE), home_state, done_r};
               end
               `AHS_OFF_POS: hrdata_nxt = 32'(pos_r);
               `AHS_OFF_VEL: hrdata_nxt = 32'(vf_r);
               default: hrdata_nxt = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_r <= '0;
         slew_r <= `AHS_SPEED_RST;
         hvel_r <= `AHS_SPEED_RST;
         acc_r <= `AHS_SPEED_RST;
         dec_r <= `AHS_SPEED_RST;
         servo_r <= `AHS_SERVO_ONE;
         step_r <= `AHS_STEP_MIN;
         mode_home_r <= 1'b0;
         mode_set_r <= 1'b0;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         hrdata_r <= 32'h0000_0000;
      end else begin
         cfg_r <= cfg_nxt;
         slew_r <= slew_nxt;
         hvel_r <= hvel_nxt;
         acc_r <= acc_nxt;
         dec_r <= dec_nxt;
         servo_r <= servo_nxt;
         step_r <= step_nxt;
         mode_home_r <= mode_home_nxt;
         mode_set_r <= mode_set_nxt;
         wr_pend_r <= wr_pend_nxt;
         wr_addr_r <= wr_addr_nxt;
         hrdata_r <= hrdata_nxt;
      end
   end

   // Homing sequencer
   always_comb begin
      state_nxt = state_r;
      tgt_nxt = tgt_r;
      rev1_nxt = rev1_r;
      href_nxt = href_r;
      done_nxt = done_r;
      idx_nxt = idx_r;
      edge_mode_nxt = edge_mode_r;
      kill = 1'b0;
      pos_nxt = pos_r;
      if (ce && filt_r.enc_pulse && !filt_d_r.enc_pulse) begin
         pos_nxt = filt_r.enc_dir ? pos_r - VW'(1) : pos_r + VW'(1);
      end
      if (ce) begin
         case (state_r)
            AHS_IDLE: begin
               if (start_cmd && mode_set_eff) begin
                  done_nxt = 1'b0;
                  idx_nxt = 1'b0;
                  edge_mode_nxt = !mode_home_eff;
                  rev1_nxt = home_state;
                  href_nxt = home_state;
                  tgt_nxt = home_state ? -$signed(slew_r) : $signed(slew_r);
                  state_nxt = AHS_FIND;
               end
            end
            AHS_FIND: begin
               if (home_state != href_r) begin
                  tgt_nxt = '0;
                  state_nxt = AHS_STOP1;
               end
            end
            AHS_STOP1: begin
               if (stopped) begin
                  if (edge_mode_r) begin
                     done_nxt = 1'b1;
                     state_nxt = AHS_IDLE;
                  end else begin
                     href_nxt = home_state;
                     tgt_nxt = rev1_r ? $signed(hvel_r) : -$signed(hvel_r);
                     state_nxt = AHS_SEEK2;
                  end
               end
            end
            AHS_SEEK2: begin
               if (home_state != href_r) begin
                  kill = !rev1_r;
                  tgt_nxt = $signed(hvel_r);
                  state_nxt = AHS_SEEK3;
               end
            end
            AHS_SEEK3: begin
               if (filt_r.index && !filt_d_r.index) begin
                  pos_nxt = '0;
                  idx_nxt = 1'b1;
                  tgt_nxt = '0;
                  state_nxt = AHS_STOP3;
               end
            end
            AHS_STOP3: begin
               if (stopped) begin
                  tgt_nxt = (pos_r > 0) ? -$signed(hvel_r) : $signed(hvel_r);
                  state_nxt = AHS_RETURN;
               end
            end
            AHS_RETURN: begin
               if (pos_r == '0 || (tgt_r > 0 && pos_r > 0) || (tgt_r < 0 && pos_r < 0)) begin
                  kill = 1'b1;
                  tgt_nxt = '0;
                  done_nxt = 1'b1;
                  state_nxt = AHS_IDLE;
               end
            end
            default: begin
               kill = 1'b1;
               tgt_nxt = '0;
               state_nxt = AHS_IDLE;
            end
         endcase
         if (abort_cmd) begin
            kill = 1'b1;
            tgt_nxt = '0;
            state_nxt = AHS_IDLE;
         end
      end
   end

   // Trapezoidal profile and smoothing filter
   logic signed [VW-1:0] stp, diff, delta;
   logic signed [VW+9:0] prod;
   logic [3:0] sh;
   always_comb begin
      v_nxt = v_r;
      vf_nxt = vf_r;
      stp = '0;
      sh = ahs_log2(step_r);
      diff = v_r - vf_r;
      prod = diff * $signed({1'b0, servo_r});
      delta = '0;
      if (cfg_r.step_axis) begin
         delta = diff >>> sh;
      end else begin
         delta = VW'(prod >>> `AHS_SMOOTH_FRAC);
      end
      if (delta == '0 && diff != '0) begin
         delta = (diff > 0) ? VW'(1) : -VW'(1);
      end
      if (ce && tick) begin
         if (v_r < tgt_r) begin
            stp = (v_r >= 0) ? $signed(acc_r) : $signed(dec_r);
            v_nxt = (tgt_r - v_r > stp) ? v_r + stp : tgt_r;
         end else if (v_r > tgt_r) begin
            stp = (v_r <= 0) ? $signed(acc_r) : $signed(dec_r);
            v_nxt = (v_r - tgt_r > stp) ? v_r - stp : tgt_r;
         end
         vf_nxt = vf_r + delta;
      end
      if (kill) begin
         v_nxt = '0;
         vf_nxt = '0;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= AHS_IDLE;
         tgt_r <= '0;
         rev1_r <= 1'b0;
         href_r <= 1'b0;
         done_r <= 1'b0;
         idx_r <= 1'b0;
         edge_mode_r <= 1'b0;
         pos_r <= '0;
         v_r <= '0;
         vf_r <= '0;
      end else begin
         state_r <= state_nxt;
         tgt_r <= tgt_nxt;
         rev1_r <= rev1_nxt;
         href_r <= href_nxt;
         done_r <= done_nxt;
         idx_r <= idx_nxt;
         edge_mode_r <= edge_mode_nxt;
         pos_r <= pos_nxt;
         v_r <= v_nxt;
         vf_r <= vf_nxt;
      end
   end

   assign motor_vel = vf_r;
   assign motor_dir = vf_r[VW-1];
   assign motion_complete = done_r;

endmodule : ahs_axis

`default_nettype wire

// ---- core/ahs_defs.svh ----
// Register offsets, field positions, reset values and limits of the axis homing block
`ifndef AHS_DEFS_SVH
`define AHS_DEFS_SVH

`define AHS_OFF_CMD 8'h00
`define AHS_OFF_CFG 8'h04
`define AHS_OFF_SLEW 8'h08
`define AHS_OFF_HVEL 8'h0c
`define AHS_OFF_ACC 8'h10
`define AHS_OFF_DEC 8'h14
`define AHS_OFF_SERVO 8'h18
`define AHS_OFF_STEP 8'h1c
`define AHS_OFF_STATUS 8'h20
`define AHS_OFF_POS 8'h24
`define AHS_OFF_VEL 8'h28

`define AHS_CMD_EDGE 0
`define AHS_CMD_HOME 1
`define AHS_CMD_BEGIN 2
`define AHS_CMD_ABORT 3

`define AHS_CFG_POL 0
`define AHS_CFG_STEP 1

`define AHS_ST_DONE 0
`define AHS_ST_HOME 1
`define AHS_ST_BUSY 2
`define AHS_ST_IDXSEEN 3
`define AHS_ST_STATE_LO 4

`define AHS_SERVO_ONE 9'h100
`define AHS_STEP_MIN 9'h001
`define AHS_STEP_MAX 9'h100
`define AHS_SMOOTH_FRAC 8
`define AHS_SPEED_RST 32'h0000_0000
`define AHS_HSIZE_WORD 3'b010

`endif

// ---- core/ahs_pkg.sv ----
// Types shared by the axis homing and smoothing block
package ahs_pkg;

   typedef enum logic [2:0] {
      AHS_IDLE = 3'b000,
      AHS_FIND = 3'b001,
      AHS_STOP1 = 3'b011,
      AHS_SEEK2 = 3'b010,
      AHS_SEEK3 = 3'b110,
      AHS_STOP3 = 3'b111,
      AHS_RETURN = 3'b101
   } ahs_state_e;

   typedef struct packed {
      logic step_axis;
      logic pol_pos;
   } ahs_cfg_s;

   typedef struct packed {
      logic home;
      logic index;
      logic enc_pulse;
      logic enc_dir;
   } ahs_pins_s;

endpackage : ahs_pkg

// ---- verification/ahs_axis_properties.sv ----
// Port-level checker of the axis homing block
`timescale 1ns/1ps
`default_nettype none
module ahs_axis_properties #(
   parameter int VW = 32
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic tick,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   input wire logic [VW-1:0] motor_vel,
   input wire logic motor_dir,
   input wire logic motion_complete
);
   logic acc;
   logic wr_r;
   logic wr_nxt;
   assign acc = hsel && htrans[1] && hready && ce;
   // Write data phase in progress
   always_comb begin
      wr_nxt = ce ? (acc && hwrite) : wr_r;
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) wr_r <= 1'b0;
      else wr_r <= wr_nxt;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   a_ready_follows_ce: assert property (hreadyout == ce) else $error("hreadyout differs from ce");
   a_resp_always_okay: assert property (hresp == 1'b0) else $error("error response seen");
   a_dir_sign_bit: assert property (motor_dir == motor_vel[VW-1]) else $error("motor_dir not sign");
   a_done_at_rest: assert property (motion_complete |-> motor_vel == '0) else $error("moving while done");
   a_freeze_on_ce: assert property (!ce |=> $stable(motor_vel) && $stable(motion_complete))
      else $error("state moved with ce low");
   a_vel_step_tick: assert property ($changed(motor_vel) && motor_vel != '0 |-> $past(ce && tick))
      else $error("velocity stepped off tick");
   a_done_holds: assert property (motion_complete && !wr_r |=> motion_complete)
      else $error("complete dropped without write");
   a_rdata_stands: assert property (!acc |=> $stable(hrdata)) else $error("hrdata changed while idle");
   c_done: cover property ($rose(motion_complete));
   c_reverse: cover property (motor_dir);
   c_frozen: cover property (!ce && motor_vel != '0);
endmodule : ahs_axis_properties
bind ahs_axis ahs_axis_properties #(.VW(VW)) i_props (.mclk(mclk), .reset_n(reset_n), .ce(ce), .tick(tick),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
   .hresp(hresp), .motor_vel(motor_vel), .motor_dir(motor_dir), .motion_complete(motion_complete));
`default_nettype wire

// ---- verification/ahs_motor_model.sv ----
// Amplifier, encoder, home switch and index model
`timescale 1ns/1ps
`default_nettype none
module ahs_motor_model #(
   parameter int HOME_AT = 12,
   parameter int IDX_AT = 16
) (
   input wire logic mclk,
   input wire logic ce,
   input wire logic tick,
   input wire logic [31:0] motor_vel,
   output logic home_pin,
   output logic index_pin,
   output logic enc_pulse_pin,
   output logic enc_dir_pin
);
   int acc = 0;
   int cnt = 0;
   int ph = 0;
   initial begin
      enc_pulse_pin = 1'b0;
      enc_dir_pin = 1'b0;
   end
   // Shaft follows commanded velocity, one encoder pulse per count
   always @(posedge mclk) begin
      if (ce && tick) acc <= acc + $signed(motor_vel);
      if (ph == 0 && cnt != acc) begin
         enc_dir_pin <= cnt > acc;
         ph <= 1;
      end else if (ph != 0) begin
         enc_pulse_pin <= ph < 6;
         if (ph == 6) cnt <= enc_dir_pin ? cnt - 1 : cnt + 1;
         ph <= (ph == 11) ? 0 : ph + 1;
      end
   end
   assign home_pin = cnt >= HOME_AT;
   assign index_pin = cnt == IDX_AT;
endmodule : ahs_motor_model
`default_nettype wire

// ---- verification/axis_homing_and_profile_smoothing_test.sv ----
// Self-checking bench of the axis homing block
`timescale 1ns/1ps
`default_nettype none
`include "ahs_defs.svh"
module axis_homing_and_profile_smoothing_test;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic ce = 1'b1;
   logic tick = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = `AHS_HSIZE_WORD;
   logic [31:0] hwdata = '0;
   logic hreadyout, hresp, motor_dir, motion_complete;
   logic home_pin, index_pin, enc_pulse_pin, enc_dir_pin;
   logic [31:0] hrdata, motor_vel, rq;
   logic [4:0] tcnt = '0;
   int err_count = 0;
   int checked = 0;
   always #2 mclk = ~mclk;
   always @(posedge mclk) begin
      tcnt <= tcnt + 5'h01;
      tick <= tcnt == 5'h1f;
   end
   ahs_axis i_dut (.mclk(mclk), .reset_n(reset_n), .ce(ce), .tick(tick), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .home_pin(home_pin), .index_pin(index_pin),
      .enc_pulse_pin(enc_pulse_pin), .enc_dir_pin(enc_dir_pin), .motor_vel(motor_vel),
      .motor_dir(motor_dir), .motion_complete(motion_complete));
   ahs_motor_model i_motor (.mclk(mclk), .ce(ce), .tick(tick), .motor_vel(motor_vel), .home_pin(home_pin),
      .index_pin(index_pin), .enc_pulse_pin(enc_pulse_pin), .enc_dir_pin(enc_dir_pin));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // One single transfer; read data lands in rq
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= wr;
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      rq = hrdata;
   endtask : bus
   task automatic wait_move;
      int n;
      n = 0;
      while (motor_vel === '0 && n < 500) begin
         @(posedge mclk);
         n++;
      end
   endtask : wait_move
   task automatic test_regs;
      bus(1'b0, `AHS_OFF_SERVO, 0);
      chk("servo reset", 32'h100, rq);
      bus(1'b0, `AHS_OFF_STEP, 0);
      chk("step reset", 32'h1, rq);
      bus(1'b1, `AHS_OFF_SERVO, 32'h1ff);
      bus(1'b0, `AHS_OFF_SERVO, 0);
      chk("servo clamp", 32'h100, rq);
      bus(1'b1, `AHS_OFF_STEP, 32'h300);
      bus(1'b0, `AHS_OFF_STEP, 0);
      chk("step top", 32'h100, rq);
      bus(1'b1, `AHS_OFF_STEP, 0);
      bus(1'b0, `AHS_OFF_STEP, 0);
      chk("step floor", 32'h1, rq);
      bus(1'b0, 8'h3c, 0);
      chk("unmapped", 32'h0, rq);
      bus(1'b1, `AHS_OFF_SERVO, 32'h100);
      $display("test_regs done");
   endtask : test_regs
   task automatic test_polarity;
      bus(1'b0, `AHS_OFF_STATUS, 0);
      chk("home state pol0", 32'h0, {31'h0, rq[1]});
      bus(1'b1, `AHS_OFF_CFG, 32'h1);
      bus(1'b0, `AHS_OFF_STATUS, 0);
      chk("home state pol1", 32'h1, {31'h0, rq[1]});
      bus(1'b1, `AHS_OFF_CFG, 32'h0);
      bus(1'b1, `AHS_OFF_SLEW, 32'h2);
      bus(1'b1, `AHS_OFF_HVEL, 32'h1);
      bus(1'b1, `AHS_OFF_ACC, 32'h1);
      bus(1'b1, `AHS_OFF_DEC, 32'h2);
      $display("test_polarity done");
   endtask : test_polarity
   task automatic test_edge(input logic exp_dir);
      int n;
      logic h0;
      h0 = home_pin;
      bus(1'b1, `AHS_OFF_CMD, 32'h5);
      wait_move();
      chk("edge direction", {31'h0, exp_dir}, {31'h0, motor_dir});
      n = 0;
      while (motion_complete !== 1'b1 && n < 3000) begin
         @(posedge mclk);
         n++;
      end
      chk("edge complete", 32'h1, {31'h0, motion_complete});
      chk("edge passed", {31'h0, !h0}, {31'h0, home_pin});
      bus(1'b0, `AHS_OFF_STATUS, 0);
      chk("edge idle", 32'h0, {29'h0, rq[6:4]});
      $display("test_edge done");
   endtask : test_edge
   task automatic test_home;
      int n;
      logic rev;
      logic idx;
      logic [31:0] v;
      rev = 1'b0;
      idx = 1'b0;
      bus(1'b1, `AHS_OFF_CMD, 32'h6);
      wait_move();
      chk("stage one direction", 32'h0, {31'h0, motor_dir});
      ce <= 1'b0;
      @(posedge mclk);
      v = motor_vel;
      repeat (40) @(posedge mclk);
      chk("frozen velocity", v, motor_vel);
      ce <= 1'b1;
      n = 0;
      while (motion_complete !== 1'b1 && n < 8000) begin
         @(posedge mclk);
         rev |= motor_dir;
         idx |= index_pin;
         n++;
      end
      chk("stage two reverse", 32'h1, {31'h0, rev});
      chk("index before done", 32'h1, {31'h0, idx});
      chk("home complete", 32'h1, {31'h0, motion_complete});
      repeat (200) @(posedge mclk);
      bus(1'b0, `AHS_OFF_POS, 0);
      chk("home position", 32'h1, {31'h0, ($signed(rq) >= -2 && $signed(rq) <= 1)});
      chk("back at index", 32'h1, {31'h0, (i_motor.cnt >= 14 && i_motor.cnt <= 17)});
      $display("test_home done");
   endtask : test_home
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      test_regs();
      test_polarity();
      test_edge(1'b0);
      test_edge(1'b1);
      test_home();
      give_verdict();
   end
   initial begin
      repeat (40000) @(posedge mclk);
      err_count++;
      give_verdict();
   end
endmodule : axis_homing_and_profile_smoothing_test
`default_nettype wire
